//--- tks_pkg.sv
// Shared constants for the touch key status sequencer and its host controller
//
// Summary of operation
// - Mode pin high at power-up: fixed standalone settings
// - Twelve channels; three may form one slider
// - Standalone channel 1 is a sensitive guard
// - Standalone channel 0 is a proximity channel
// - Channels 2 to 11 may become outputs
// - Output select bit 0; level bit 1
// - Standalone outputs follow keys 2 to 6
// - Base cycle 16 ms; acquire every N cycles
// - Interval has 255 nonzero values, host writable
// - Calibration, touch or integration force every cycle
// - Interval zero powers down; nonzero at 8 resumes
// - Three suppression groups; one detect per group
// - Host puts guard key in protected group
// - Any key may be a proximity channel
// - Host disables unused keys 2 to 11 via bit 0
// - Status change asserts change; status read releases
// - Returned status held per byte until that byte is read again
// - Release after all differing status bytes read
// - Change at 85 ms; bursts 16 ms later
// - Host writes output setup within that window
// - Serial traffic wakes device; host awaits change
// - Detect integrator: 0 acts as 1, above 32 blocks
package tks_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned BASE_NS = 16000000;
  localparam int unsigned BASE_CYC = BASE_NS / CLK_NS;
  localparam int unsigned BOOT_NS = 85000000;
  localparam int unsigned BOOT_CYC = BOOT_NS / CLK_NS;
  localparam int unsigned I2C_QTR_NS = 625;
  localparam int unsigned I2C_QTR_CYC = (I2C_QTR_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // Device register map
  localparam logic [6:0] DEV_ADDR = 7'h1c;
  localparam logic [7:0] REG_DET = 8'h02;
  localparam logic [7:0] REG_KEY_LO = 8'h03;
  localparam logic [7:0] REG_KEY_HI = 8'h04;
  localparam logic [7:0] REG_CAL = 8'h06;
  localparam logic [7:0] REG_ACQ = 8'h08;
  localparam logic [7:0] REG_DI = 8'h0b;
  localparam logic [7:0] REG_SLIDER = 8'h0e;
  localparam logic [7:0] REG_KCTL = 8'h1c;
  localparam logic [7:0] ACQ_RST = 8'h01;
  localparam logic [7:0] DI_RST = 8'h04;
  localparam logic [7:0] SA_INTERVAL = 8'h01;
  localparam logic [7:0] SA_DI = 8'h04;
  localparam logic [7:0] DI_MAX = 8'h20;
  localparam logic [3:0] CAL_ACQS = 4'hf;
  // Key control fields
  localparam int KC_OUTSEL = 0;
  localparam int KC_LEVEL = 1;
  localparam int KC_GRP = 2;
  localparam int KC_GUARD = 4;
  localparam int KC_PROX = 5;
  localparam int SLD_EN = 6;
  // Detection status fields
  localparam int DET_TOUCH = 0;
  localparam int DET_PROX = 1;
  localparam int DET_SLIDER = 2;
  localparam int DET_CAL = 7;
  // ==========================================================
  // Host controller registers
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_READ = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_CHG = 2;
  localparam int STAT_RDATA_LSB = 8;
endpackage

//--- tks_if.sv
// Two-wire serial link and change line between host controller and device
interface tks_if;
  logic scl_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic change_oe;
  logic scl;
  logic sda;
  logic change_n;
  // Open-drain wires with pull-ups
  assign scl = ~scl_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  assign change_n = ~change_oe;
  modport dev(input scl, input sda, output sda_dev_oe, output change_oe);
  modport host(input sda, input change_n, output scl_oe, output sda_host_oe);
endinterface

//--- tks_device.sv
// Touch key status sequencer: serial slave, registers, scheduling, detection
//
// The two-wire serial register port was chosen for this implementation.
module tks_device #(
  parameter int unsigned BASE_CYCLES = tks_pkg::BASE_CYC,
  parameter int unsigned BOOT_CYCLES = tks_pkg::BOOT_CYC,
  parameter logic [6:0] SLAVE_ADDR = tks_pkg::DEV_ADDR
) (
  input wire logic hclk,
  input wire logic hresetn,
  tks_if.dev link,
  input wire logic mode_pin,
  input wire logic [11:0] key_sense,
  output logic [11:0] key_out,
  output logic [11:0] key_oe,
  output logic prox_oe,
  output logic acquire,
  output logic asleep
);
  typedef enum logic [3:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_PTR, SL_PACK, SL_WR, SL_WACK, SL_RD, SL_RACK} tks_sl_t;

  // ==========================================================
  // Synchronisers
  logic [1:0] scl_s, sda_s, mode_s;
  logic scl_p, sda_p;
  logic [11:0] sense_m, sense_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      mode_s <= 2'h0;
      sense_m <= 12'h000;
      sense_s <= 12'h000;
    end else begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
      scl_p <= scl_s[1];
      sda_p <= sda_s[1];
      mode_s <= {mode_s[0], mode_pin};
      sense_m <= key_sense;
      sense_s <= sense_m;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s[1] & ~scl_p;
  assign scl_fall = ~scl_s[1] & scl_p;
  assign start_det = scl_s[1] & scl_p & sda_p & ~sda_s[1];
  assign stop_det = scl_s[1] & scl_p & ~sda_p & sda_s[1];

  // ==========================================================
  // Start-up sequence and mode strap
  logic [31:0] boot_q;
  logic standalone_q, run_q, boot_chg, run_go;
  assign boot_chg = boot_q == BOOT_CYCLES - 1;
  assign run_go = boot_q == BOOT_CYCLES + BASE_CYCLES - 1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_q <= 32'h0;
      standalone_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (!run_q) boot_q <= boot_q + 32'h1;
      if (boot_q == 32'h3) standalone_q <= mode_s[1];
      if (run_go) run_q <= 1'b1;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] acq_q, di_q, sld_q, ld_q, ptr_q;
  logic [7:0] kctl_q [12];
  logic [7:0] rd_data, wr_data, kidx;
  logic wr_go, rd_done;
  logic [7:0] snap_q [3];
  logic [7:0] stat_b [3];
  assign kidx = ptr_q - tks_pkg::REG_KCTL;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_q <= tks_pkg::ACQ_RST;
      di_q <= tks_pkg::DI_RST;
      sld_q <= 8'h00;
      for (int i = 0; i < 12; i++) kctl_q[i] <= 8'h00;
    end else if (wr_go) begin
      if (ptr_q == tks_pkg::REG_ACQ) acq_q <= wr_data;
      if (ptr_q == tks_pkg::REG_DI) di_q <= wr_data;
      if (ptr_q == tks_pkg::REG_SLIDER) sld_q <= wr_data;
      if (ptr_q >= tks_pkg::REG_KCTL && kidx < 8'd12) kctl_q[kidx[3:0]] <= wr_data;
    end
  end
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q >= tks_pkg::REG_KCTL && kidx < 8'd12) rd_data = kctl_q[kidx[3:0]];
    unique case (ptr_q)
      tks_pkg::REG_DET: rd_data = stat_b[0];
      tks_pkg::REG_KEY_LO: rd_data = stat_b[1];
      tks_pkg::REG_KEY_HI: rd_data = stat_b[2];
      tks_pkg::REG_ACQ: rd_data = acq_q;
      tks_pkg::REG_DI: rd_data = di_q;
      tks_pkg::REG_SLIDER: rd_data = sld_q;
      default: ;
    endcase
  end

  // ==========================================================
  // Serial slave
  tks_sl_t sl_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic rw_q, nack_q, sda_oe_q;
  assign wr_go = scl_fall && sl_q == SL_WR && bit_q == 4'h8;
  assign wr_data = sh_q;
  assign rd_done = scl_fall && sl_q == SL_RD && bit_q == 4'h7;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sl_q <= SL_IDLE;
      sh_q <= 8'h00;
      ld_q <= 8'h00;
      bit_q <= 4'h0;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_det || standalone_q) begin
      sl_q <= SL_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      sl_q <= SL_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (sl_q == SL_ADDR || sl_q == SL_PTR || sl_q == SL_WR) begin
        sh_q <= {sh_q[6:0], sda_s[1]};
        bit_q <= bit_q + 4'h1;
      end
      if (sl_q == SL_RACK) nack_q <= sda_s[1];
    end else if (scl_fall) begin
      unique case (sl_q)
        SL_IDLE: ;
        SL_ADDR: if (bit_q == 4'h8) begin
          if (sh_q[7:1] == SLAVE_ADDR) begin
            sl_q <= SL_AACK;
            rw_q <= sh_q[0];
            sda_oe_q <= 1'b1;
          end else sl_q <= SL_IDLE;
        end
        SL_AACK, SL_RACK: if ((sl_q == SL_AACK && rw_q) || (sl_q == SL_RACK && !nack_q)) begin
          sl_q <= SL_RD;
          sh_q <= rd_data;
          ld_q <= rd_data;
          bit_q <= 4'h0;
          sda_oe_q <= ~rd_data[7];
        end else begin
          sl_q <= (sl_q == SL_AACK) ? SL_PTR : SL_IDLE;
          bit_q <= 4'h0;
          sda_oe_q <= 1'b0;
        end
        SL_PTR: if (bit_q == 4'h8) begin
          ptr_q <= sh_q;
          sl_q <= SL_PACK;
          sda_oe_q <= 1'b1;
        end
        SL_PACK, SL_WACK: begin
          sl_q <= SL_WR;
          bit_q <= 4'h0;
          sda_oe_q <= 1'b0;
        end
        SL_WR: if (bit_q == 4'h8) begin
          sl_q <= SL_WACK;
          sda_oe_q <= 1'b1;
          ptr_q <= ptr_q + 8'h1;
        end
        SL_RD: if (bit_q == 4'h7) begin
          sl_q <= SL_RACK;
          sda_oe_q <= 1'b0;
          ptr_q <= ptr_q + 8'h1;
        end else begin
          sh_q <= {sh_q[6:0], 1'b0};
          bit_q <= bit_q + 4'h1;
          sda_oe_q <= ~sh_q[6];
        end
      endcase
    end
  end
  assign link.sda_dev_oe = sda_oe_q;

  // ==========================================================
  // Channel roles
  logic [11:0] sense_en, guard, prox;
  logic [1:0] grp [12];
  logic [7:0] di_eff, interval;
  always_comb begin
    di_eff = standalone_q ? tks_pkg::SA_DI : ((di_q == 8'h00) ? 8'h01 : di_q);
    interval = standalone_q ? tks_pkg::SA_INTERVAL : acq_q;
    for (int i = 0; i < 12; i++) begin
      if (standalone_q) begin
        sense_en[i] = i <= 6;
        grp[i] = (i >= 1 && i <= 6) ? 2'h1 : 2'h0;
        guard[i] = i == 1;
        prox[i] = i == 0;
      end else begin
        sense_en[i] = !(i >= 2 && kctl_q[i][tks_pkg::KC_OUTSEL]);
        grp[i] = kctl_q[i][tks_pkg::KC_GRP +: 2];
        guard[i] = kctl_q[i][tks_pkg::KC_GUARD];
        prox[i] = kctl_q[i][tks_pkg::KC_PROX];
      end
    end
  end

  // ==========================================================
  // Detect integrator and suppression groups
  logic [11:0] det_q, det_d;
  logic [5:0] dcnt_q [12];
  logic [5:0] dcnt_d [12];
  logic [3:0] busy;
  logic [3:0] cal_q;
  logic [7:0] di_use;
  logic cal_active, integrating;
  assign cal_active = cal_q != 4'h0;
  always_comb begin
    det_d = det_q;
    busy = 4'h0;
    integrating = 1'b0;
    di_use = 8'h01;
    for (int i = 0; i < 12; i++) begin
      dcnt_d[i] = dcnt_q[i];
      if (dcnt_q[i] != 6'h0) integrating = 1'b1;
      if (det_q[i]) busy[grp[i]] = 1'b1;
    end
    if (acquire) begin
      for (int i = 0; i < 12; i++) begin
        di_use = guard[i] ? 8'h01 : di_eff;
        if (!sense_en[i] || cal_active) begin
          det_d[i] = 1'b0;
          dcnt_d[i] = 6'h0;
        end else if (sense_s[i] == det_q[i]) begin
          dcnt_d[i] = 6'h0;
        end else if (!det_q[i] && ((grp[i] != 2'h0 && busy[grp[i]]) || di_eff > tks_pkg::DI_MAX)) begin
          dcnt_d[i] = 6'h0;
        end else if ({2'h0, dcnt_q[i]} + 8'h1 >= di_use) begin
          det_d[i] = ~det_q[i];
          dcnt_d[i] = 6'h0;
          if (!det_q[i]) busy[grp[i]] = 1'b1;
        end else begin
          dcnt_d[i] = dcnt_q[i] + 6'h1;
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_q <= 12'h000;
      for (int i = 0; i < 12; i++) dcnt_q[i] <= 6'h0;
    end else begin
      det_q <= det_d;
      for (int i = 0; i < 12; i++) dcnt_q[i] <= dcnt_d[i];
    end
  end

  // ==========================================================
  // Acquisition scheduling
  logic [31:0] base_q;
  logic [7:0] lp_q;
  logic base_tick, acq_go, asleep_q;
  // First burst lands at the end of the post-boot window, not one base cycle later
  assign base_tick = run_go || (run_q && base_q == BASE_CYCLES - 1);
  assign acq_go = base_tick && interval != 8'h00 &&
    (cal_active || (|det_q) || integrating || lp_q + 8'h1 >= interval);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_q <= 32'h0;
      lp_q <= 8'h00;
      acquire <= 1'b0;
      asleep_q <= 1'b0;
      cal_q <= 4'h0;
    end else begin
      base_q <= (!run_q || base_tick) ? 32'h0 : base_q + 32'h1;
      if (base_tick) lp_q <= acq_go ? 8'h00 : lp_q + 8'h1;
      acquire <= acq_go;
      if (start_det || acq_go) asleep_q <= 1'b0;
      else if (base_tick) asleep_q <= 1'b1;
      if (run_go || (wr_go && ptr_q == tks_pkg::REG_CAL && wr_data != 8'h00)) cal_q <= tks_pkg::CAL_ACQS;
      else if (acquire && cal_active) cal_q <= cal_q - 4'h1;
    end
  end
  assign asleep = asleep_q;

  // ==========================================================
  // Status bytes and change line
  logic [11:0] key_rep;
  logic [7:0] snap_d [3];
  logic [23:0] stat_p_q;
  logic chg_q, diff;
  assign key_rep = det_q & ~(sld_q[tks_pkg::SLD_EN] ? 12'h007 : 12'h000);
  always_comb begin
    stat_b[0] = 8'h00;
    stat_b[0][tks_pkg::DET_TOUCH] = |(key_rep & ~prox);
    stat_b[0][tks_pkg::DET_PROX] = |(det_q & prox);
    stat_b[0][tks_pkg::DET_SLIDER] = sld_q[tks_pkg::SLD_EN] & (|det_q[2:0]);
    stat_b[0][tks_pkg::DET_CAL] = cal_active;
    stat_b[1] = key_rep[7:0];
    stat_b[2] = {4'h0, key_rep[11:8]};
    diff = 1'b0;
    for (int b = 0; b < 3; b++) begin
      snap_d[b] = (rd_done && ptr_q == tks_pkg::REG_DET + 8'(b)) ? ld_q : snap_q[b];
      if (snap_d[b] != stat_b[b]) diff = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_p_q <= 24'h0;
      chg_q <= 1'b0;
      for (int b = 0; b < 3; b++) snap_q[b] <= 8'h00;
    end else begin
      stat_p_q <= {stat_b[2], stat_b[1], stat_b[0]};
      for (int b = 0; b < 3; b++) snap_q[b] <= snap_d[b];
      if (!standalone_q && (boot_chg || stat_p_q != {stat_b[2], stat_b[1], stat_b[0]})) chg_q <= 1'b1;
      else if (rd_done && !diff) chg_q <= 1'b0;
    end
  end
  assign link.change_oe = chg_q;

  // ==========================================================
  // Pin drivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_out <= 12'h000;
      key_oe <= 12'h000;
      prox_oe <= 1'b0;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (standalone_q) begin
          key_oe[i] <= i >= 7;
          key_out[i] <= (i >= 7) ? det_q[(i >= 7) ? i - 5 : 0] : 1'b0;
        end else begin
          key_oe[i] <= !sense_en[i];
          key_out[i] <= !sense_en[i] && kctl_q[i][tks_pkg::KC_LEVEL];
        end
      end
      prox_oe <= standalone_q && det_q[0];
    end
  end
endmodule // tks_device

//--- tks_host.sv
// Host controller: AHB-Lite register slave driving the two-wire serial master
module tks_host #(
  parameter int unsigned QTR_CYCLES = tks_pkg::I2C_QTR_CYC,
  parameter logic [6:0] SLAVE_ADDR = tks_pkg::DEV_ADDR
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  tks_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tks_hs_t;

  // ==========================================================
  // Synchronisers
  logic [1:0] sda_s, chg_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_s <= 2'h3;
      chg_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], link.sda};
      chg_s <= {chg_s[0], link.change_n};
    end
  end

  // ==========================================================
  // Bus slave
  tks_hs_t hs_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q, rdata_q, c_addr_q, c_data_q;
  logic c_read_q, nack_q, go;
  assign go = ap_wr_q && ap_addr_q == tks_pkg::H_CMD && hs_q == H_IDLE;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      c_addr_q <= 8'h00;
      c_data_q <= 8'h00;
      c_read_q <= 1'b0;
    end else begin
      ap_wr_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      ap_addr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata <= 32'h0;
        if (haddr[7:0] == tks_pkg::H_STAT) begin
          hrdata[tks_pkg::STAT_BUSY] <= hs_q != H_IDLE;
          hrdata[tks_pkg::STAT_NACK] <= nack_q;
          hrdata[tks_pkg::STAT_CHG] <= ~chg_s[1];
          hrdata[tks_pkg::STAT_RDATA_LSB +: 8] <= rdata_q;
        end
      end
      if (go) begin
        c_addr_q <= hwdata[tks_pkg::CMD_ADDR_LSB +: 8];
        c_data_q <= hwdata[tks_pkg::CMD_DATA_LSB +: 8];
        c_read_q <= hwdata[tks_pkg::CMD_READ];
      end
    end
  end

  // ==========================================================
  // Serial master
  logic [31:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bitn_q;
  logic [2:0] step_q;
  logic [7:0] sh_q, next_byte;
  logic scl_oe_q, sda_oe_q, tick;
  assign tick = hs_q != H_IDLE && div_q == QTR_CYCLES - 1;
  always_comb begin
    unique case (step_q)
      3'h0: next_byte = c_addr_q;
      3'h1: next_byte = c_read_q ? {SLAVE_ADDR, 1'b1} : c_data_q;
      default: next_byte = 8'hff;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= H_IDLE;
      div_q <= 32'h0;
      ph_q <= 2'h0;
      bitn_q <= 4'h0;
      step_q <= 3'h0;
      sh_q <= 8'h00;
      rdata_q <= 8'h00;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (go) begin
      hs_q <= H_START;
      div_q <= 32'h0;
      ph_q <= 2'h0;
      step_q <= 3'h0;
      nack_q <= 1'b0;
      sh_q <= {SLAVE_ADDR, 1'b0};
    end else if (hs_q != H_IDLE) begin
      div_q <= tick ? 32'h0 : div_q + 32'h1;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        unique case (hs_q)
          H_IDLE: ;
          H_START: begin
            if (ph_q == 2'h0) sda_oe_q <= 1'b0;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b1;
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              hs_q <= H_BIT;
              bitn_q <= 4'h0;
            end
          end
          H_BIT: begin
            if (ph_q == 2'h0) sda_oe_q <= (bitn_q < 4'h8 && step_q != 3'h3) ? ~sh_q[7] : 1'b0;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) begin
              if (bitn_q < 4'h8) sh_q <= {sh_q[6:0], sda_s[1]};
              else if (step_q != 3'h3 && sda_s[1]) nack_q <= 1'b1;
            end
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == 4'h8) begin
                bitn_q <= 4'h0;
                step_q <= step_q + 3'h1;
                sh_q <= next_byte;
                if (step_q == 3'h3) rdata_q <= sh_q;
                if (nack_q || step_q == 3'h3 || (step_q == 3'h2 && !c_read_q)) hs_q <= H_STOP;
                else if (step_q == 3'h1 && c_read_q) hs_q <= H_START;
              end
            end
          end
          H_STOP: begin
            if (ph_q == 2'h0) sda_oe_q <= 1'b1;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b0;
            if (ph_q == 2'h3) hs_q <= H_IDLE;
          end
        endcase
      end
    end
  end
  assign link.scl_oe = scl_oe_q;
  assign link.sda_host_oe = sda_oe_q;
endmodule // tks_host

//--- tks_checker.sv
// Concurrent checks on the serial link and change line between host and device
module tks_checker #(
  parameter int unsigned BOOT_CYCLES = tks_pkg::BOOT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic change_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic change_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Helper counters
  int unsigned boot_cnt;
  logic [4:0] hi_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) boot_cnt <= 0;
    else if (boot_cnt < BOOT_CYCLES + 8) boot_cnt <= boot_cnt + 1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_cnt <= 5'h00;
    else if (!scl) hi_cnt <= 5'h00;
    else if (hi_cnt != 5'h1f) hi_cnt <= hi_cnt + 5'h01;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Assertions
  chg_wire_a: assert property (change_n == !change_oe)
    else $error("change wire level wrong");
  sda_wire_a: assert property (sda == !(sda_host_oe | sda_dev_oe))
    else $error("data wire level wrong");
  reset_quiet_a: assert property ($rose(hresetn) |-> !change_oe [*8])
    else $error("change asserted right after reset");
  boot_quiet_a: assert property (boot_cnt + 3 < BOOT_CYCLES |-> !change_oe)
    else $error("change asserted before boot time");
  boot_chg_a: assert property (boot_cnt == BOOT_CYCLES + 4 |-> change_oe)
    else $error("change not asserted at boot time");
  dev_hold_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data moved while clock high");
  dev_idle_a: assert property (hi_cnt > 5'h0f |-> !sda_dev_oe)
    else $error("device drives data on idle bus");
  chg_clear_a: assert property ($fell(change_oe) |-> !scl)
    else $error("change released outside a read byte");
  cover property ($fell(change_oe));
  cover property ($rose(sda_dev_oe));
  cover property (boot_cnt >= BOOT_CYCLES + 8 && $rose(change_oe));
endmodule // tks_checker

//--- tb_top.sv
// Self-checking bench joining host controller and device
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t mismatch %0h vs %0h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 40;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mode_pin = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, s, rnd = 32'he2af7987;
  logic hreadyout, hresp, prox_oe, acquire, asleep;
  logic [11:0] key_sense = 0, key_out, key_oe;
  logic [7:0] b;
  int bad_count = 0, tests_run = 0, cyc = 0, n_acq = 0, last_acq = 0, last_gap = 0, first_acq = 0, n0;
  tks_if link();
  tks_device #(.BASE_CYCLES(BASE), .BOOT_CYCLES(100)) i_tks_device(.hclk(hclk), .hresetn(hresetn),
    .link(link), .mode_pin(mode_pin), .key_sense(key_sense), .key_out(key_out), .key_oe(key_oe),
    .prox_oe(prox_oe), .acquire(acquire), .asleep(asleep));
  tks_host #(.QTR_CYCLES(4)) i_tks_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  tks_checker #(.BOOT_CYCLES(100)) i_tks_checker(.hclk(hclk), .hresetn(hresetn), .scl_oe(link.scl_oe),
    .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe), .change_oe(link.change_oe),
    .scl(link.scl), .sda(link.sda), .change_n(link.change_n));
  always #10 hclk = ~hclk;
  // ==========================================================
  // Acquisition spacing tracker
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (acquire === 1'b1) begin
      n_acq <= n_acq + 1;
      last_gap <= cyc - last_acq;
      last_acq <= cyc;
      if (first_acq == 0) first_acq <= cyc;
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic dop(input logic r, input logic [7:0] p, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] st;
    ahb(1'b1, 32'h0, {15'h0, r, d, p}, st);
    st = 32'h1;
    for (int i = 0; i < 2000 && st[0] !== 1'b0; i++) ahb(1'b0, 32'h4, 32'h0, st);
    `CHK(st[0], 1'b0)
    `CHK(st[1], 1'b0)
    q = st[15:8];
  endtask
  task automatic wchg(input logic v);
    for (int i = 0; i < 5000 && link.change_n !== v; i++) @(posedge hclk);
    `CHK(link.change_n, v)
  endtask
  task automatic wacq(input int k);
    int m;
    m = n_acq + k;
    for (int i = 0; i < 20000 && n_acq < m; i++) @(posedge hclk);
    `CHK(n_acq >= m, 1'b1)
  endtask
  task automatic end_of_test;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h4, 32'h0, s);
    `CHK(s[2:0], 3'h0)
    wchg(1'b0);
    `CHK(cyc inside {[100:112]}, 1'b1)
    dop(1'b1, 8'h08, 8'h00, b);
    `CHK(b, 8'h01)
    for (int ch = 0; ch < 12; ch++) begin
      rnd = lfsr(rnd);
      dop(1'b0, 8'h1c + 8'(ch), {6'h0, rnd[0], 1'b1}, b);
      `CHK(key_oe[ch], 1'(ch >= 2))
      if (ch >= 2) `CHK(key_out[ch], rnd[0])
    end
    `CHK(first_acq inside {[138:152]}, 1'b1)
    rnd = lfsr(rnd);
    dop(1'b0, 8'h08, {6'h0, rnd[1:0]} + 8'h02, b);
    wacq(3);
    `CHK(last_gap, BASE * (rnd[1:0] + 2))
    dop(1'b0, 8'h08, 8'h00, b);
    n0 = n_acq;
    repeat (300) @(posedge hclk);
    `CHK(n_acq, n0)
    `CHK(asleep, 1'b1)
    dop(1'b0, 8'h08, 8'h05, b);
    wacq(1);
    `CHK(n_acq > n0, 1'b1)
    dop(1'b1, 8'h02, 8'h00, b);
    dop(1'b1, 8'h03, 8'h00, b);
    dop(1'b1, 8'h04, 8'h00, b);
    `CHK(link.change_n, 1'b1)
    key_sense[0] <= 1'b1;
    wchg(1'b0);
    key_sense[0] <= 1'b0;
    wacq(8);
    `CHK(link.change_n, 1'b0)
    dop(1'b1, 8'h0b, 8'h00, b);
    `CHK(link.change_n, 1'b1)
    key_sense[0] <= 1'b1;
    wchg(1'b0);
    wacq(2);
    `CHK(last_gap, BASE)
    dop(1'b1, 8'h02, 8'h00, b);
    `CHK(b[0], 1'b1)
    `CHK(link.change_n, 1'b0)
    dop(1'b1, 8'h03, 8'h00, b);
    `CHK(b, 8'h01)
    `CHK(link.change_n, 1'b1)
    dop(1'b0, 8'h1c, 8'h04, b);
    dop(1'b0, 8'h1d, 8'h14, b);
    key_sense[1] <= 1'b1;
    wacq(8);
    dop(1'b1, 8'h03, 8'h00, b);
    `CHK(b, 8'h01)
    // Second reset with the strap high: standalone pin roles
    mode_pin <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK(key_oe, 12'hf80)
    `CHK(prox_oe, 1'b0)
    `CHK(link.change_n, 1'b1)
    end_of_test;
  end
  initial begin
    #1200000;
    bad_count++;
    end_of_test;
  end
endmodule // tb_top
